// *** rtl/interrupt_mask_clear_autoclear.sv ***
`timescale 1ns/1ns
module interrupt_mask_clear_autoclear
  import int_mask_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // avalon-mm slave
  input  wire logic                    avsRead,
  input  wire logic                    avsWrite,
  input  wire logic [7:0]              avsAddress,
  input  wire logic [3:0]              avsByteenable,
  input  wire logic [31:0]             avsWritedata,
  output logic      [31:0]             avsReaddata_r,
  output logic                         avsWaitrequest_r,
  // neighbouring cause sources and mode
  input  wire logic [31:0]             causeEvent,
  input  wire logic                    msixMode,
  // toward the host bus interface
  output logic                         intRequest_r,
  output logic [AUTO_CLEAR_W-1:0]      msixVectorReq_r,
  output logic [31:0]                  maskVector_r,
  output logic [31:0]                  causeVector_r,
  output logic                         irq_r
);

  avalonReq_type   req;
  busState_type    busState_r;
  busState_type    busState_nxt;
  logic [31:0]     autoClear_r;
  logic [31:0]     autoMask_r;
  logic [31:0]     extControl_r;
  logic [EVT_W-1:0] evtMask_r;
  logic [EVT_W-1:0] evtStatus;
  logic [31:0]     maskBits;
  logic [31:0]     causeBits;
  logic [31:0]     laneMask;
  logic [31:0]     wrData;
  logic [31:0]     rdNxt;
  logic            mapped;
  logic            commit;
  logic            doWrite;
  logic            doRead;
  logic            causeAccess;
  logic            autoMaskHit;
  logic            intAsserted;
  logic [31:0]     maskSet;
  logic [31:0]     maskClr;
  logic [31:0]     causeSet;
  logic [31:0]     causeClr;
  logic [31:0]     autoFire;
  logic [EVT_W-1:0] evtSet;
  logic [EVT_W-1:0] evtClr;

  assign req.read       = avsRead;
  assign req.write      = avsWrite;
  assign req.address    = avsAddress;
  assign req.byteenable = avsByteenable;
  assign req.writedata  = avsWritedata;

  // bus handshake: waitrequest drops one cycle after a request shows,
  // the access commits on the edge where the master sees it low
  always_comb begin
    busState_nxt = busState_r;
    case (busState_r)
      BUS_IDLE: begin
        if (req.read || req.write) begin
          busState_nxt = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        busState_nxt = BUS_IDLE;
      end
      default: begin
        busState_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busState_r <= BUS_IDLE;
    end else begin
      busState_r <= busState_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avsWaitrequest_r <= 1'b1;
    end else begin
      avsWaitrequest_r <= (busState_nxt != BUS_ANSWER);
    end
  end

  assign commit  = (busState_r == BUS_ANSWER) && (req.read || req.write);
  assign doWrite = commit && req.write;
  assign doRead  = commit && req.read;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      laneMask[i*8 +: 8] = {8{req.byteenable[i]}};
    end
  end

  assign wrData = req.writedata & laneMask;

  always_comb begin
    case (req.address)
      OFS_CAUSE_READ, OFS_CAUSE_SET, OFS_MASK_SET, OFS_MASK_CLEAR,
      OFS_AUTO_CLEAR, OFS_AUTO_MASK, OFS_EXT_CONTROL,
      OFS_EVENT_STATUS, OFS_EVENT_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // read data, captured as waitrequest drops so it stands stable
  // through the committing edge
  always_comb begin
    rdNxt = RST_WORD;
    case (req.address)
      OFS_CAUSE_READ: begin
        rdNxt = causeBits & DEFINED_BITS;
        rdNxt[BIT_INT_ASSERTED] = intAsserted;
      end
      OFS_MASK_SET:     rdNxt = maskBits;
      OFS_AUTO_CLEAR:   rdNxt = autoClear_r;
      OFS_AUTO_MASK:    rdNxt = autoMask_r;
      OFS_EXT_CONTROL:  rdNxt = extControl_r;
      OFS_EVENT_STATUS: rdNxt = {{(32-EVT_W){1'b0}}, evtStatus};
      OFS_EVENT_MASK:   rdNxt = {{(32-EVT_W){1'b0}}, evtMask_r};
      default:          rdNxt = RST_WORD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avsReaddata_r <= RST_WORD;
    end else if (busState_nxt == BUS_ANSWER && req.read) begin
      avsReaddata_r <= rdNxt;
    end
  end

  // plain read/write configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      autoClear_r <= RST_WORD;
    end else if (doWrite && req.address == OFS_AUTO_CLEAR) begin
      // only the queue/other field stores; the rest reads zero
      autoClear_r <= (autoClear_r & ~laneMask & AUTO_CLEAR_BITS)
                   | (wrData & AUTO_CLEAR_BITS);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      autoMask_r <= RST_WORD;
    end else if (doWrite && req.address == OFS_AUTO_MASK) begin
      autoMask_r <= (autoMask_r & ~laneMask) | wrData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extControl_r <= RST_WORD;
    end else if (doWrite && req.address == OFS_EXT_CONTROL) begin
      extControl_r[EXT_AUTO_MASK_ENABLE] <=
        req.byteenable[0] ? req.writedata[EXT_AUTO_MASK_ENABLE]
                          : extControl_r[EXT_AUTO_MASK_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evtMask_r <= RST_EVT;
    end else if (doWrite && req.address == OFS_EVENT_MASK) begin
      evtMask_r <= (evtMask_r & ~laneMask[EVT_W-1:0])
                 | wrData[EVT_W-1:0];
    end
  end

  // mask vector
  assign causeAccess = commit && (req.address == OFS_CAUSE_READ);
  assign autoMaskHit = causeAccess && intAsserted
                     && extControl_r[EXT_AUTO_MASK_ENABLE];

  always_comb begin
    maskSet = RST_WORD;
    maskClr = RST_WORD;
    if (doWrite && req.address == OFS_MASK_SET) begin
      maskSet = wrData & DEFINED_BITS;
    end
    if (doWrite && req.address == OFS_MASK_CLEAR) begin
      // zeros in the write leave their masks untouched
      maskClr = wrData & DEFINED_BITS;
    end
    if (autoMaskHit) begin
      maskClr = maskClr | (autoMask_r & DEFINED_BITS);
    end
  end

  sticky_bits #(
    .W (32)
  ) maskStore (
    .clk     (clk),
    .rst_n   (rst_n),
    .setBits (maskSet),
    .clrBits (maskClr),
    .bits_r  (maskBits)
  );

  // cause vector: events and cause-set writes win over any clear
  assign autoFire = causeBits & maskBits & autoClear_r
                  & {32{msixMode}};

  always_comb begin
    causeSet = causeEvent & DEFINED_BITS;
    causeClr = autoFire;
    if (doWrite && req.address == OFS_CAUSE_SET) begin
      causeSet = causeSet | (wrData & DEFINED_BITS);
    end
    if (doWrite && req.address == OFS_CAUSE_READ) begin
      causeClr = causeClr | wrData;
    end
    if (doRead && req.address == OFS_CAUSE_READ) begin
      // clear only what the read returned, so later events survive
      causeClr = causeClr | avsReaddata_r;
    end
  end

  sticky_bits #(
    .W (32)
  ) causeStore (
    .clk     (clk),
    .rst_n   (rst_n),
    .setBits (causeSet),
    .clrBits (causeClr),
    .bits_r  (causeBits)
  );

  // auto-cleared causes leave through their vector and also drive the legacy line until they clear
  assign intAsserted = |(causeBits & maskBits & DEFINED_BITS);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intRequest_r <= 1'b0;
    end else begin
      intRequest_r <= intAsserted;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msixVectorReq_r <= '0;
    end else begin
      msixVectorReq_r <= autoFire[AUTO_CLEAR_HI:AUTO_CLEAR_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maskVector_r  <= RST_WORD;
      causeVector_r <= RST_WORD;
    end else begin
      maskVector_r  <= maskBits;
      causeVector_r <= causeBits;
    end
  end

  // block event status, write one to clear, masked onto irq
  always_comb begin
    evtSet = RST_EVT;
    evtSet[EVT_AUTO_MASK] = autoMaskHit;
    evtSet[EVT_AUTO_CLR]  = |autoFire;
    evtSet[EVT_UNMAPPED]  = commit && !mapped;
    evtClr = RST_EVT;
    if (doWrite && req.address == OFS_EVENT_STATUS) begin
      evtClr = wrData[EVT_W-1:0];
    end
  end

  sticky_bits #(
    .W (EVT_W)
  ) evtStore (
    .clk     (clk),
    .rst_n   (rst_n),
    .setBits (evtSet),
    .clrBits (evtClr),
    .bits_r  (evtStatus)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evtStatus & evtMask_r);
    end
  end

endmodule

// *** rtl/int_mask_pkg.sv ***
package int_mask_pkg;

  // register byte offsets on the Avalon-MM slave
  localparam logic [7:0] OFS_CAUSE_READ   = 8'hC0;
  localparam logic [7:0] OFS_CAUSE_SET    = 8'hC8;
  localparam logic [7:0] OFS_MASK_SET     = 8'hD0;
  localparam logic [7:0] OFS_MASK_CLEAR   = 8'hD8;
  localparam logic [7:0] OFS_AUTO_CLEAR   = 8'hDC;
  localparam logic [7:0] OFS_AUTO_MASK    = 8'hE0;
  localparam logic [7:0] OFS_EXT_CONTROL  = 8'hF0;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'hF4;
  localparam logic [7:0] OFS_EVENT_MASK   = 8'hF8;

  // cause / mask bit positions
  localparam int BIT_TX_WRITEBACK    = 0;
  localparam int BIT_TX_QUEUE_EMPTY  = 1;
  localparam int BIT_LINK_CHANGE     = 2;
  localparam int BIT_RX_DESC_THRESH  = 4;
  localparam int BIT_RX_OVERRUN      = 6;
  localparam int BIT_RX_TIMER        = 7;
  localparam int BIT_MGMT_BUS_DONE   = 9;
  localparam int BIT_TX_DESC_LOW     = 15;
  localparam int BIT_SMALL_RX_PACKET = 16;
  localparam int BIT_ACK_FRAME       = 17;
  localparam int BIT_MANAGEABILITY   = 18;
  localparam int BIT_RX_QUEUE_ZERO   = 20;
  localparam int BIT_RX_QUEUE_ONE    = 21;
  localparam int BIT_TX_QUEUE_ZERO   = 22;
  localparam int BIT_TX_QUEUE_ONE    = 23;
  localparam int BIT_OTHER           = 24;
  localparam int BIT_INT_ASSERTED    = 31;

  localparam int AUTO_CLEAR_LO = 20;
  localparam int AUTO_CLEAR_HI = 24;
  localparam int AUTO_CLEAR_W  = AUTO_CLEAR_HI - AUTO_CLEAR_LO + 1;

  // every defined cause bit; reserved bits never store
  localparam logic [31:0] DEFINED_BITS = 32'h01F7_82D7;
  localparam logic [31:0] AUTO_CLEAR_BITS = 32'h01F0_0000;

  // extended control bits
  localparam int EXT_AUTO_MASK_ENABLE = 0;

  // block event status bits
  localparam int EVT_AUTO_MASK = 0;
  localparam int EVT_AUTO_CLR  = 1;
  localparam int EVT_UNMAPPED  = 2;
  localparam int EVT_W         = 3;

  // reset values
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } busState_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avalonReq_type;

endpackage

// *** rtl/sticky_bits.sv ***
`timescale 1ns/1ns
// set wins over a clear arriving in the same cycle
module sticky_bits #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] setBits,
  input  wire logic [W-1:0] clrBits,
  output logic      [W-1:0] bits_r
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_r <= '0;
    end else begin
      bits_r <= (bits_r & ~clrBits) | setBits;
    end
  end

endmodule

// *** bench/int_mask_sva.sv ***
`timescale 1ns/1ns
module int_mask_sva
  import int_mask_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [7:0]  avsAddress,
  input wire logic [3:0]  avsByteenable,
  input wire logic [31:0] avsWritedata,
  input wire logic [31:0] avsReaddata_r,
  input wire logic        avsWaitrequest_r,
  input wire logic [31:0] maskVector_r,
  input wire logic [31:0] causeVector_r,
  input wire logic        intRequest_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // commit edges of full-word writes and of reads
  sequence s_wr(a);
    !avsWaitrequest_r && avsWrite && avsAddress == a && avsByteenable == 4'hF;
  endsequence
  sequence s_rd(a);
    !avsWaitrequest_r && avsRead && avsAddress == a;
  endsequence
  property p_wait_pulse;
    !avsWaitrequest_r |=> avsWaitrequest_r;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low twice");
  property p_wait_req;
    !avsWaitrequest_r |-> avsRead || avsWrite;
  endproperty
  a_wait_req: assert property (p_wait_req) else $error("no request");
  // mask copy lags the commit by one more edge
  property p_clear;
    s_wr(OFS_MASK_CLEAR) |-> ##2
      maskVector_r == ($past(maskVector_r) & ~$past(avsWritedata, 2));
  endproperty
  a_clear: assert property (p_clear) else $error("mask clear");
  property p_set;
    s_wr(OFS_MASK_SET) |-> ##2 maskVector_r ==
      ($past(maskVector_r) | ($past(avsWritedata, 2) & DEFINED_BITS));
  endproperty
  a_set: assert property (p_set) else $error("mask set wrong");
  property p_req;
    intRequest_r == |(causeVector_r & maskVector_r & DEFINED_BITS);
  endproperty
  a_req: assert property (p_req) else $error("request mismatch");
  property p_read_mask;
    s_rd(OFS_MASK_SET) |-> avsReaddata_r == maskVector_r;
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("mask read");
  property p_cause_set;
    s_wr(OFS_CAUSE_SET) |-> ##2 (causeVector_r & $past(avsWritedata, 2)
      & DEFINED_BITS) == ($past(avsWritedata, 2) & DEFINED_BITS);
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause set");
  property p_auto_rd;
    s_rd(OFS_AUTO_CLEAR) |-> (avsReaddata_r & ~AUTO_CLEAR_BITS) == 0;
  endproperty
  a_auto_rd: assert property (p_auto_rd) else $error("auto clear read");
  property p_clr_rd;
    s_rd(OFS_MASK_CLEAR) |-> avsReaddata_r == 0;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("mask clear read");
endmodule
bind interrupt_mask_clear_autoclear int_mask_sva int_mask_sva_i (
  .clk, .rst_n, .avsRead, .avsWrite, .avsAddress, .avsByteenable,
  .avsWritedata, .avsReaddata_r, .avsWaitrequest_r, .maskVector_r,
  .causeVector_r, .intRequest_r);

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb
  import int_mask_pkg::*;
;
  logic clk = 0, rst_n = 0, avsRead = 0, avsWrite = 0, msixMode = 0;
  logic [7:0] avsAddress = 0;
  logic [3:0] avsByteenable = 4'hF;
  logic [31:0] avsWritedata = 0, causeEvent = 0, avsReaddata_r;
  logic [31:0] maskVector_r, causeVector_r, q[$], m, r, c, am;
  logic [4:0] msixVectorReq_r;
  logic avsWaitrequest_r, intRequest_r, irq_r;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  int bits[16] = '{0, 1, 2, 4, 6, 7, 9, 15, 16, 17, 18, 20, 21, 22, 23, 24};
  interrupt_mask_clear_autoclear interrupt_mask_clear_autoclear_i (
    .clk, .rst_n, .avsRead, .avsWrite, .avsAddress, .avsByteenable,
    .avsWritedata, .avsReaddata_r, .avsWaitrequest_r, .causeEvent,
    .msixMode, .intRequest_r, .msixVectorReq_r, .maskVector_r,
    .causeVector_r, .irq_r);
  always #4 clk = ~clk;
  task automatic final_report;
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avsWrite <= w;
    avsRead <= !w;
    avsAddress <= a;
    avsWritedata <= d;
    avsByteenable <= be;
    // no local limit: only the bench timeout ends a hung access
    do begin
      @(posedge clk);
    end while (avsWaitrequest_r !== 1'b0);
    avsWrite <= 0;
    avsRead <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(0, a, 0, 4'hF);
  endtask
  // registered outputs land one edge after the commit
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk)
    if (avsRead && avsWaitrequest_r === 1'b0 && q.size() > 0)
      chk(avsReaddata_r, q.pop_front());
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report;
    end
  end
  initial begin
    void'($urandom(32'h0000_552d));
    repeat (5) @(posedge clk);
    rst_n <= 1;
    wr(OFS_MASK_SET, 32'hFFFF_FFFF);
    m = DEFINED_BITS;
    rd(OFS_MASK_SET, m);
    foreach (bits[i]) begin
      wr(OFS_MASK_CLEAR, 32'h0000_0001 << bits[i]);
      m[bits[i]] = 0;
      rd(OFS_MASK_SET, m);
    end
    repeat (4) begin
      r = $urandom;
      c = $urandom & 32'h01FF_FFFF;
      wr(OFS_MASK_SET, r);
      wr(OFS_MASK_CLEAR, c);
      m = (m | r) & DEFINED_BITS & ~c;
      rd(OFS_MASK_SET, m);
    end
    rd(OFS_MASK_CLEAR, 0);
    wr(OFS_MASK_SET, DEFINED_BITS);
    wr(OFS_CAUSE_SET, 32'h0000_0004);
    settle;
    chk(intRequest_r, 1);
    wr(OFS_MASK_CLEAR, 32'h0000_0004);
    settle;
    chk(intRequest_r, 0);
    rd(OFS_CAUSE_READ, 32'h0000_0004);
    m = DEFINED_BITS & ~32'h0000_0004;
    c = $urandom;
    causeEvent <= c;
    @(posedge clk);
    causeEvent <= 0;
    c &= DEFINED_BITS;
    rd(OFS_CAUSE_READ, c | {|(c & m), 31'h0000_0000});
    am = $urandom;
    wr(OFS_AUTO_MASK, am);
    wr(OFS_EXT_CONTROL, 1);
    wr(OFS_MASK_SET, DEFINED_BITS);
    // no cause pending, so the access must not mask anything
    wr(OFS_CAUSE_READ, 0);
    rd(OFS_MASK_SET, DEFINED_BITS);
    wr(OFS_CAUSE_SET, 32'h0000_0001);
    wr(OFS_CAUSE_READ, 32'h0000_0001);
    rd(OFS_MASK_SET, DEFINED_BITS & ~am);
    bus(1, OFS_AUTO_MASK, 0, 4'h3);
    rd(OFS_AUTO_MASK, am & 32'hFFFF_0000);
    wr(OFS_EXT_CONTROL, 0);
    msixMode <= 1;
    wr(OFS_AUTO_CLEAR, 32'h01FF_FFFF);
    rd(OFS_AUTO_CLEAR, AUTO_CLEAR_BITS);
    wr(OFS_MASK_SET, DEFINED_BITS);
    causeEvent <= AUTO_CLEAR_BITS | 32'h0000_0001;
    @(posedge clk);
    causeEvent <= 0;
    for (int i = 0; i < 8 && msixVectorReq_r === 5'h00; i++)
      @(posedge clk);
    chk(msixVectorReq_r, 5'h1F);
    // the cause copy trails the vector pulse by one edge
    @(posedge clk);
    chk(msixVectorReq_r, 5'h00);
    chk(causeVector_r, 32'h0000_0001);
    // cause read is avoided while auto-clear is in use
    wr(OFS_CAUSE_READ, 32'h0000_0001);
    settle;
    chk(causeVector_r, 0);
    msixMode <= 0;
    rd(8'h44, 0);
    wr(OFS_EVENT_MASK, 32'h0000_0007);
    settle;
    chk(irq_r, 1);
    rd(OFS_EVENT_STATUS, 32'h0000_0007);
    wr(OFS_EVENT_STATUS, 32'h0000_0007);
    settle;
    chk(irq_r, 0);
    wr(OFS_EVENT_MASK, 32'h0000_0003);
    wr(8'h44, 32'hFFFF_FFFF);
    settle;
    chk(irq_r, 0);
    rd(OFS_EVENT_STATUS, 32'h0000_0004);
    final_report;
  end
endmodule
